// >>> pcrm_top.sv
// pcrm_top: classifier table behind axi4-lite plus one-cycle rule match
// assumes packet fields arrive on aclk from the mac domain datapath
// Operation
// - each packet, ingress or egress, is checked against the classifier list
// - a classifier matches only when all its present parameters pass; presence bits 6 to 20 are stored but never checked in the match
// - a presence map per classifier; absent parameters other than state read as defaults
// - presence bits: priority 0, state 1, tos 2, up to icmp high 20
// - larger priority value is examined before smaller
// - absent priority: 0 for provisioned, 64 for dynamic flows
// - tos floor is an 8-bit octet, reported zero when absent
// - queue number zero only marks upstream drop classifiers, never binds
// - classifier identifier unique within its queue; drop ones use reference; only id writes are checked for it, queue and ctrl writes are not
// - each classifier applies only to its own direction
// - protocol 256 any, 257 tcp or udp, 258 reported when absent
// - source matches when address and mask equals configured address
`timescale 1ns/100ps
module pcrm_top
  import pcrm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pkt_valid,
  output logic                   pkt_ready,
  input  wire logic              pkt_egress,
  input  wire logic [15:0]       pkt_if_number,
  input  wire logic [7:0]        pkt_tos,
  input  wire logic [7:0]        pkt_protocol,
  input  wire logic [31:0]       pkt_src_addr,
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic                   res_hit,
  output logic                   res_drop,
  output logic [31:0]            res_queue,
  output logic [15:0]            res_class_id
);
  // ------------------------------------------------------------
  // classifier table storage
  // ------------------------------------------------------------
  logic [3:0]       ctrl_q  [ENTRIES];
  logic [MAP_W-1:0] map_q   [ENTRIES];
  logic [7:0]       prio_q  [ENTRIES];
  logic [31:0]      queue_q [ENTRIES];
  logic [15:0]      id_q    [ENTRIES];
  logic [23:0]      tos_q   [ENTRIES];
  logic [8:0]       proto_q [ENTRIES];
  logic [31:0]      src_q   [ENTRIES];
  logic [31:0]      smask_q [ENTRIES];
  logic [15:0]      ifnum_q [ENTRIES];

  // ------------------------------------------------------------
  // effective values per entry (all but eff_act are reported)
  // ------------------------------------------------------------
  logic [7:0]       eff_prio  [ENTRIES];
  logic [7:0]       eff_floor [ENTRIES];
  logic [23:0]      eff_tos   [ENTRIES];
  logic [8:0]       eff_proto [ENTRIES];
  logic [31:0]      eff_src   [ENTRIES];
  logic [31:0]      eff_smask [ENTRIES];
  logic             eff_act   [ENTRIES];
  logic [ENTRIES-1:0] hit;

  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    logic pass_tos;
    logic pass_proto;
    logic pass_src;
    logic [7:0] tos_m;
    assign eff_prio[i] = map_q[i][P_PRIO] ? prio_q[i] :
                         (ctrl_q[i][C_DYNAMIC] ? PRIO_DYN : PRIO_PROV);
    assign eff_tos[i]   = map_q[i][P_TOS] ? tos_q[i] : 24'h00_0000;
    assign eff_floor[i] = map_q[i][P_TOS] ? tos_q[i][7:0] : TOS_FLOOR_D;
    assign eff_proto[i] = map_q[i][P_PROTO] ? proto_q[i] : PROTO_NONE;
    assign eff_src[i]   = map_q[i][P_SRC] ? src_q[i] : SRC_D;
    assign eff_smask[i] = map_q[i][P_SMASK] ? smask_q[i] : SMASK_D;
    // an entry that never signalled its state counts as active
    assign eff_act[i]   = map_q[i][P_STATE] ? ctrl_q[i][C_ACTIVE] : 1'b1;
    assign tos_m = pkt_tos & tos_q[i][23:16];
    assign pass_tos = !map_q[i][P_TOS] ||
                      (tos_m >= tos_q[i][7:0] && tos_m <= tos_q[i][15:8]);
    always_comb begin
      if (!map_q[i][P_PROTO] || proto_q[i] == PROTO_ANY) begin
        pass_proto = 1'b1;
      end else if (proto_q[i] == PROTO_TCPUDP) begin
        pass_proto = pkt_protocol == PROTO_TCP || pkt_protocol == PROTO_UDP;
      end else begin
        pass_proto = {1'b0, pkt_protocol} == proto_q[i];
      end
    end
    assign pass_src = (pkt_src_addr & eff_smask[i]) == eff_src[i] ||
                      !(map_q[i][P_SRC] || map_q[i][P_SMASK]);
    // drop entries (queue zero) only see upstream, i.e. ingress, traffic
    assign hit[i] = ctrl_q[i][C_VALID] && eff_act[i] &&
                    ctrl_q[i][C_EGRESS] == pkt_egress &&
                    ifnum_q[i] == pkt_if_number &&
                    !(queue_q[i] == QUEUE_DROP && pkt_egress) &&
                    pass_tos && pass_proto && pass_src;
  end

  // ------------------------------------------------------------
  // best match selection
  // ------------------------------------------------------------
  logic             best_hit;
  logic [IDX_W-1:0] best_idx;
  always_comb begin
    best_hit = 1'b0;
    best_idx = '0;
    for (int k = 0; k < ENTRIES; k++) begin
      if (hit[k] && (!best_hit ||
          eff_prio[k] > eff_prio[best_idx] ||
          (eff_prio[k] == eff_prio[best_idx] &&
           id_q[k] < id_q[best_idx]))) begin
        best_hit = 1'b1;
        best_idx = k[IDX_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // packet handshake and result registers
  // ------------------------------------------------------------
  logic        rv_q;
  logic        hit_q;
  logic        drop_q;
  logic [31:0] rq_q;
  logic [15:0] rid_q;
  logic [31:0] hits_q;
  logic [IDX_W-1:0] last_idx_q;
  logic        take_pkt;

  // one packet per cycle; the result slot stalls intake when held
  assign pkt_ready = !rv_q || res_ready;
  assign take_pkt  = pkt_valid && pkt_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_q <= 1'b0;
    end else if (take_pkt) begin
      rv_q <= 1'b1;
    end else if (res_ready) begin
      rv_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q      <= 1'b0;
      drop_q     <= 1'b0;
      rq_q       <= '0;
      rid_q      <= '0;
      last_idx_q <= '0;
    end else if (take_pkt) begin
      hit_q      <= best_hit;
      drop_q     <= best_hit && queue_q[best_idx] == QUEUE_DROP;
      rq_q       <= best_hit ? queue_q[best_idx] : QUEUE_DROP;
      rid_q      <= best_hit ? id_q[best_idx] : 16'h0000;
      last_idx_q <= best_idx;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hits_q <= '0;
    end else if (take_pkt && best_hit) begin
      hits_q <= hits_q + 32'h0000_0001;
    end
  end

  assign res_valid    = rv_q;
  assign res_hit      = hit_q;
  assign res_drop     = drop_q;
  assign res_queue    = rq_q;
  assign res_class_id = rid_q;

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  logic             bv_q;
  logic [1:0]       br_q;
  logic             wr_go;
  logic [IDX_W-1:0] widx;
  logic [3:0]       wreg;
  logic             wtab;
  logic             dup;
  logic [31:0]      wmask;
  logic [31:0]      wcur;
  logic [31:0]      wnew;

  // address and data are taken together, once both are offered
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bv_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign widx = s_axi_awaddr[8:6];
  assign wreg = s_axi_awaddr[5:2];
  assign wtab = !s_axi_awaddr[11] && !s_axi_awaddr[10] &&
                !s_axi_awaddr[9] && wreg <= R_IFNUM;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always_comb begin
    case (wreg)
      R_CTRL:  wcur = {28'h000_0000, ctrl_q[widx]};
      R_MAP:   wcur = {11'h000, map_q[widx]};
      R_PRIO:  wcur = {24'h00_0000, prio_q[widx]};
      R_QUEUE: wcur = queue_q[widx];
      R_ID:    wcur = {16'h0000, id_q[widx]};
      R_TOS:   wcur = {8'h00, tos_q[widx]};
      R_PROTO: wcur = {23'h00_0000, proto_q[widx]};
      R_SRC:   wcur = src_q[widx];
      R_SMASK: wcur = smask_q[widx];
      R_IFNUM: wcur = {16'h0000, ifnum_q[widx]};
      default: wcur = 32'h0000_0000;
    endcase
  end
  assign wnew = (s_axi_wdata & wmask) | (wcur & ~wmask);

  // an identifier already used by another valid entry of the same queue
  // is refused on an id write; queue and ctrl writes are not checked for it
  always_comb begin
    dup = 1'b0;
    for (int j = 0; j < ENTRIES; j++) begin
      if (j[IDX_W-1:0] != widx && ctrl_q[j][C_VALID] &&
          queue_q[j] == queue_q[widx] && id_q[j] == wnew[15:0]) begin
        dup = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < ENTRIES; e++) begin
        ctrl_q[e]  <= 4'h0;
        map_q[e]   <= '0;
        prio_q[e]  <= 8'h00;
        queue_q[e] <= 32'h0000_0000;
        id_q[e]    <= 16'h0000;
        tos_q[e]   <= 24'h00_0000;
        proto_q[e] <= 9'h000;
        src_q[e]   <= 32'h0000_0000;
        smask_q[e] <= 32'h0000_0000;
        ifnum_q[e] <= 16'h0000;
      end
    end else if (wr_go && wtab && !(wreg == R_ID && dup)) begin
      case (wreg)
        R_CTRL:  ctrl_q[widx]  <= wnew[3:0];
        R_MAP:   map_q[widx]   <= wnew[MAP_W-1:0];
        R_PRIO:  prio_q[widx]  <= wnew[7:0];
        R_QUEUE: queue_q[widx] <= wnew;
        R_ID:    id_q[widx]    <= wnew[15:0];
        R_TOS:   tos_q[widx]   <= wnew[23:0];
        R_PROTO: proto_q[widx] <= wnew[8:0];
        R_SRC:   src_q[widx]   <= wnew;
        R_SMASK: smask_q[widx] <= wnew;
        R_IFNUM: ifnum_q[widx] <= wnew[15:0];
        default: ctrl_q[widx]  <= ctrl_q[widx];
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      br_q <= RESP_OKAY;
    end else if (wr_go) begin
      bv_q <= 1'b1;
      if (!wtab) begin
        br_q <= RESP_DECERR;
      end else if (wreg == R_ID && dup) begin
        br_q <= RESP_SLVERR;
      end else begin
        br_q <= RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      bv_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp  = br_q;

  // ------------------------------------------------------------
  // axi4-lite read channel (absent parameters other than state show defaults)
  // ------------------------------------------------------------
  logic             rvq;
  logic [31:0]      rd_q;
  logic [1:0]       rr_q;
  logic [IDX_W-1:0] ridx;
  logic [3:0]       rreg;
  logic [31:0]      rval;
  logic             rok;

  assign s_axi_arready = !rvq;
  assign ridx = s_axi_araddr[8:6];
  assign rreg = s_axi_araddr[5:2];

  always_comb begin
    rok  = 1'b1;
    rval = 32'h0000_0000;
    if (s_axi_araddr == A_LAST) begin
      rval = {24'h00_0000, 1'b0, hit_q, drop_q, 2'b00, last_idx_q};
    end else if (s_axi_araddr == A_HITS) begin
      rval = hits_q;
    end else if (s_axi_araddr[11:9] != 3'b000) begin
      rok = 1'b0;
    end else begin
      case (rreg)
        R_CTRL:  rval = {28'h000_0000, ctrl_q[ridx][3:1] & 3'b111,
                         ctrl_q[ridx][C_VALID]};
        R_MAP:   rval = {11'h000, map_q[ridx]};
        R_PRIO:  rval = {24'h00_0000, eff_prio[ridx]};
        R_QUEUE: rval = queue_q[ridx];
        R_ID:    rval = {16'h0000, id_q[ridx]};
        R_TOS:   rval = {8'h00, eff_tos[ridx][23:8], eff_floor[ridx]};
        R_PROTO: rval = {23'h00_0000, eff_proto[ridx]};
        R_SRC:   rval = eff_src[ridx];
        R_SMASK: rval = eff_smask[ridx];
        R_IFNUM: rval = {16'h0000, ifnum_q[ridx]};
        default: rok  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvq  <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvq) begin
      rvq  <= 1'b1;
      rd_q <= rval;
      rr_q <= rok ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvq  <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvq;
  assign s_axi_rdata  = rd_q;
  assign s_axi_rresp  = rr_q;
endmodule : pcrm_top

// >>> pcrm_pkg.sv
// pcrm_pkg: constants for the packet classifier rule match block
// assumes a 32-bit axi4-lite slave and a 12-bit byte address
package pcrm_pkg;
  // ------------------------------------------------------------
  // table geometry
  // ------------------------------------------------------------
  localparam int          ENTRIES     = 8;
  localparam int          IDX_W       = 3;
  localparam int          ADDR_W      = 12;
  localparam int          MAP_W       = 21;
  // ------------------------------------------------------------
  // per-entry word offsets (entry base = index * 0x40)
  // ------------------------------------------------------------
  localparam logic [3:0]  R_CTRL      = 4'h0;
  localparam logic [3:0]  R_MAP       = 4'h1;
  localparam logic [3:0]  R_PRIO      = 4'h2;
  localparam logic [3:0]  R_QUEUE     = 4'h3;
  localparam logic [3:0]  R_ID        = 4'h4;
  localparam logic [3:0]  R_TOS       = 4'h5;
  localparam logic [3:0]  R_PROTO     = 4'h6;
  localparam logic [3:0]  R_SRC       = 4'h7;
  localparam logic [3:0]  R_SMASK     = 4'h8;
  localparam logic [3:0]  R_IFNUM     = 4'h9;
  localparam logic [11:0] A_LAST      = 12'h0200;
  localparam logic [11:0] A_HITS      = 12'h0204;
  // ------------------------------------------------------------
  // control and presence bit positions
  // ------------------------------------------------------------
  localparam int          C_VALID     = 0;
  localparam int          C_EGRESS    = 1;
  localparam int          C_DYNAMIC   = 2;
  localparam int          C_ACTIVE    = 3;
  localparam int          P_PRIO      = 0;
  localparam int          P_STATE     = 1;
  localparam int          P_TOS       = 2;
  localparam int          P_PROTO     = 3;
  localparam int          P_SRC       = 4;
  localparam int          P_SMASK     = 5;
  localparam int          P_ICMP_HI   = 20;
  // ------------------------------------------------------------
  // reported defaults and selector codes
  // ------------------------------------------------------------
  localparam logic [7:0]  PRIO_PROV   = 8'h00;
  localparam logic [7:0]  PRIO_DYN    = 8'h40;
  localparam logic [7:0]  TOS_FLOOR_D = 8'h00;
  localparam logic [8:0]  PROTO_ANY   = 9'h100;
  localparam logic [8:0]  PROTO_TCPUDP= 9'h101;
  localparam logic [8:0]  PROTO_NONE  = 9'h102;
  localparam logic [7:0]  PROTO_TCP   = 8'h06;
  localparam logic [7:0]  PROTO_UDP   = 8'h11;
  localparam logic [31:0] SRC_D       = 32'h0000_0000;
  localparam logic [31:0] SMASK_D     = 32'hFFFF_FFFF;
  localparam logic [31:0] QUEUE_DROP  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [1:0]  RESP_DECERR = 2'b11;
endpackage : pcrm_pkg

// >>> pcrm_top_assertions.sv
// checker for pcrm_top: result and register bus timing
// assumes it is bound to pcrm_top and sees only its ports
`timescale 1ns/100ps
module pcrm_chk
  import pcrm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        pkt_valid,
  input wire logic        pkt_ready,
  input wire logic        pkt_egress,
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic        res_hit,
  input wire logic        res_drop,
  input wire logic [31:0] res_queue,
  input wire logic [15:0] res_class_id
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // sequences
  // ----
  sequence s_take;
    pkt_valid && pkt_ready;
  endsequence
  sequence s_stall;
    res_valid && !res_ready;
  endsequence
  chk_res_answer: assert property (s_take |=> res_valid)
    else $error("no result one cycle after packet taken");
  chk_res_hold: assert property (s_stall |=> res_valid
    && $stable(res_queue) && $stable(res_class_id) && $stable(res_hit))
    else $error("stalled result changed");
  chk_stall_block: assert property (s_stall |-> !pkt_ready)
    else $error("packet accepted while result stalled");
  chk_miss_zero: assert property (res_valid && !res_hit |-> !res_drop
    && res_queue == 32'h0 && res_class_id == 16'h0)
    else $error("miss carries a queue or id");
  chk_drop_queue: assert property (res_valid && res_drop |->
    res_hit && res_queue == QUEUE_DROP)
    else $error("drop result not on queue zero");
  chk_bind_nonzero: assert property (res_valid && res_hit && !res_drop
    |-> res_queue != QUEUE_DROP)
    else $error("classifier bound to queue zero");
  chk_egress_nodrop: assert property (s_take ##0 pkt_egress
    |=> !res_drop)
    else $error("egress packet hit a drop classifier");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid
    && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response after write taken");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("no read data after read taken");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready)
    else $error("read data dropped before taken");
endmodule : pcrm_chk
bind pcrm_top pcrm_chk pcrm_chk_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pkt_valid,
  .pkt_ready, .pkt_egress, .res_valid, .res_ready, .res_hit, .res_drop,
  .res_queue, .res_class_id);

// >>> pcrm_far_model.sv
// far-side model: datapath offering packets and taking results
// assumes the bench calls send one packet at a time
`timescale 1ns/100ps
module pcrm_far_model (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   slow,
  output logic        pkt_valid,
  input  wire logic   pkt_ready,
  output logic        pkt_egress,
  output logic [15:0] pkt_if_number,
  output logic [7:0]  pkt_tos,
  output logic [7:0]  pkt_protocol,
  output logic [31:0] pkt_src_addr,
  output logic        res_ready
);
  logic [64:0] fld_q;
  logic [1:0]  cnt_q;
  initial pkt_valid = 1'b0;
  initial fld_q = '0;
  // idle fields show the inverse so a stale packet never looks valid
  assign {pkt_egress, pkt_if_number, pkt_tos, pkt_protocol, pkt_src_addr} =
    pkt_valid ? fld_q : ~fld_q;
  // slow mode holds results back on half the cycles
  always_ff @(posedge aclk) begin
    cnt_q <= aresetn ? cnt_q + 2'h1 : 2'h0;
  end
  assign res_ready = !slow || cnt_q[1];
  task automatic send(input logic e, input logic [7:0] tos, pro,
                      input logic [31:0] src, output bit ok);
    int i;
    i = 0;
    @(posedge aclk);
    pkt_valid <= 1'b1;
    fld_q     <= {e, 16'h0, tos, pro, src};
    do @(posedge aclk); while (!pkt_ready && ++i < 100);
    pkt_valid <= 1'b0;
    ok = (i < 100);
  endtask : send
endmodule : pcrm_far_model

// >>> tb_top.sv
// tb_top: self-checking bench for pcrm_top
// assumes pcrm_pkg, pcrm_far_model and the checker are compiled first
`timescale 1ns/100ps
module tb_top;
  import pcrm_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, queue, seed = 32'h0000_6eac;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        slow = 0, awready, wready, bvalid, arready, rvalid;
  logic        pv, pr, pe, rv, rr, hit, drop;
  logic [15:0] pif, cid;
  logic [7:0]  ptos, ppro;
  logic [31:0] psrc;
  int          mismatches = 0, n_tests = 0;
  logic [49:0] res_q[$];
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  always #2.5 aclk = ~aclk;
  pcrm_top pcrm_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pkt_valid(pv),
    .pkt_ready(pr), .pkt_egress(pe), .pkt_if_number(pif), .pkt_tos(ptos),
    .pkt_protocol(ppro), .pkt_src_addr(psrc), .res_valid(rv),
    .res_ready(rr), .res_hit(hit), .res_drop(drop), .res_queue(queue),
    .res_class_id(cid));
  pcrm_far_model pcrm_far_model_inst (.aclk(aclk), .aresetn(aresetn),
    .slow(slow), .pkt_valid(pv), .pkt_ready(pr), .pkt_egress(pe),
    .pkt_if_number(pif), .pkt_tos(ptos), .pkt_protocol(ppro),
    .pkt_src_addr(psrc), .res_ready(rr));
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic fail();
    mismatches++;
    print_verdict();
  endtask : fail
  task automatic cmp_res(input logic [49:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR result exp=%h got=%h", exp, got);
    end
  endtask : cmp_res
  task automatic cmp_bus(input string nm, input logic [33:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s exp=%h got=%h", nm, exp, got);
    end
  endtask : cmp_bus
  // results are judged where they appear, in the order they were noted
  always @(posedge aclk) begin
    if (rv && rr) cmp_res(res_q.pop_front(), {hit, drop, queue, cid});
    if (bvalid && bready) cmp_bus("bresp", wr_q.pop_front(), bresp);
    if (rvalid && rready) begin
      cmp_bus("rdata", rd_q.pop_front(), {rresp, rdata});
    end
  end
  // galois shift register, the only source of random packet fields
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr_next
  function automatic logic [11:0] ra(input int e, input logic [3:0] r);
    return 12'((e << 6) + (r << 2));
  endfunction : ra
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] resp);
    int i;
    i = 0;
    wr_q.push_back(resp);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (!awready && ++i < 50);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    if (i >= 50) fail();
    do @(posedge aclk); while (!bvalid && ++i < 100);
    bready  <= 1'b0;
    if (i >= 100) fail();
  endtask : wr
  // rready comes a cycle late so the read data must stand while stalled
  task automatic rd(input logic [11:0] a, input logic [1:0] resp,
                    input logic [31:0] d);
    int i;
    i = 0;
    rd_q.push_back({resp, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready && ++i < 50);
    arvalid <= 1'b0;
    if (i >= 50) fail();
    @(posedge aclk);
    rready  <= 1'b1;
    do @(posedge aclk); while (!rvalid && ++i < 100);
    rready  <= 1'b0;
    if (i >= 100) fail();
  endtask : rd
  task automatic prog(input int e, input logic [31:0] ctl, map, pri, q, id,
                      pro, src, msk);
    wr(ra(e, R_MAP), map, RESP_OKAY);
    wr(ra(e, R_PRIO), pri, RESP_OKAY);
    wr(ra(e, R_QUEUE), q, RESP_OKAY);
    wr(ra(e, R_ID), id, RESP_OKAY);
    wr(ra(e, R_PROTO), pro, RESP_OKAY);
    wr(ra(e, R_SRC), src, RESP_OKAY);
    wr(ra(e, R_SMASK), msk, RESP_OKAY);
    wr(ra(e, R_CTRL), ctl, RESP_OKAY);
  endtask : prog
  // low source bits and tos are random; the top byte picks the subnet
  task automatic pkt(input logic e, input logic [7:0] pro, net,
                     input logic h, dr, input logic [31:0] q,
                     input logic [15:0] id);
    bit ok;
    seed = lfsr_next(seed);
    res_q.push_back({h, dr, q, id});
    pcrm_far_model_inst.send(e, seed[7:0], pro, {net, seed[31:8]}, ok);
    if (!ok) fail();
  endtask : pkt
  initial begin : main
    int i;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ra(6, R_PRIO), RESP_OKAY, {24'h0, PRIO_PROV});
    rd(ra(6, R_TOS), RESP_OKAY, {24'h0, TOS_FLOOR_D});
    rd(ra(6, R_PROTO), RESP_OKAY, {23'h0, PROTO_NONE});
    rd(ra(6, R_SRC), RESP_OKAY, SRC_D);
    rd(ra(6, R_SMASK), RESP_OKAY, SMASK_D);
    wr(ra(6, R_CTRL), 32'h4, RESP_OKAY);
    rd(ra(6, R_PRIO), RESP_OKAY, {24'h0, PRIO_DYN});
    wr(ra(6, R_MAP), 32'hffff_ffff, RESP_OKAY);
    rd(ra(6, R_MAP), RESP_OKAY, 32'h001f_ffff);
    rd(12'h300, RESP_DECERR, 32'h0);
    wr(12'h300, 32'h1, RESP_DECERR);
    prog(0, 32'h1, 32'h9, 32'ha, 32'h5, 32'h1, 32'h101, 32'h0, 32'h0);
    prog(1, 32'h1, 32'h31, 32'h14, 32'h7, 32'h2, 32'h0, 32'h0a00_0000,
         32'hff00_0000);
    prog(2, 32'h1, 32'h1, 32'h5, QUEUE_DROP, 32'h3, 32'h0, 32'h0, 32'h0);
    prog(4, 32'h3, 32'h1, 32'h1, 32'h9, 32'h4, 32'h0, 32'h0, 32'h0);
    rd(ra(0, R_PRIO), RESP_OKAY, 32'ha);
    wr(ra(3, R_QUEUE), 32'h5, RESP_OKAY);
    wr(ra(3, R_ID), 32'h1, RESP_SLVERR);
    rd(ra(3, R_ID), RESP_OKAY, 32'h0);
    slow <= 1'b1;
    pkt(0, PROTO_TCP, 8'h0a, 1, 0, 32'h7, 16'h2);
    pkt(0, PROTO_UDP, 8'h0b, 1, 0, 32'h5, 16'h1);
    pkt(0, 8'h01, 8'h0b, 1, 1, QUEUE_DROP, 16'h3);
    pkt(1, PROTO_TCP, 8'h0a, 1, 0, 32'h9, 16'h4);
    wr(ra(0, R_PROTO), {23'h0, PROTO_ANY}, RESP_OKAY);
    pkt(0, 8'h01, 8'h0b, 1, 0, 32'h5, 16'h1);
    wr(ra(2, R_CTRL), 32'h0, RESP_OKAY);
    wr(ra(0, R_PROTO), {24'h0, PROTO_TCP}, RESP_OKAY);
    pkt(0, PROTO_UDP, 8'h0b, 0, 0, 32'h0, 16'h0);
    // equal priority to entry 1 at a higher index but with a lower id
    prog(5, 32'h1, 32'h1, 32'h14, 32'h8, 32'h1, 32'h0, 32'h0, 32'h0);
    pkt(0, PROTO_TCP, 8'h0a, 1, 0, 32'h8, 16'h1);
    for (i = 0; i < 100 && res_q.size() > 0; i++) @(posedge aclk);
    if (res_q.size() > 0) fail();
    rd(A_HITS, RESP_OKAY, 32'h0000_0006);
    print_verdict();
  end
endmodule : tb_top
